/* src/ttl_target_travel_limiter.sv */
// Purpose: Clamp the move-command target between two user-register bounds.
// Assumes: All inputs come from logic on clk; one trajectory step per servo cycle.
// Notes: Bounds are sampled one clock after the register file changes.
//   Out-of-range selections act as off; the wrap check and the bound hit that starts a freeze apply only while on.
//   A frozen move is released only by move_active being low.
//
// Overview of operation
// - The lower bound is data register N and the upper bound register N+1, N up to 198.
// - Move-driven targets are kept strictly above the lower and below the upper bound.
// - The lower bound is checked only on negative motion, the upper only on positive.
// - With the target already out of range, only motion back toward the range moves it.
// - A motion that meets a bound stops the target one count inside it at once, with no ramp.
// - After a hit the trajectory keeps running but no longer writes the target.
// - A direct target write bypasses the bounds check.
// - Position is linear, so a step that would wrap past full range is blocked.
// - Bounds are not validated; crossed bounds form a dead zone where nothing moves.
// - A configuration of zero turns the limiter off.

`timescale 1ns/1ps
`default_nettype none

module ttl_target_travel_limiter
  import ttl_pkg::*;
#(
  parameter int NREGS = NUM_REGS
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [IDX_W-1:0] travel_bound_config,
  input wire ttl_reg_wr_t reg_wr,
  input wire ttl_tgt_wr_t tgt_wr,
  input wire ttl_step_t step,
  input wire logic move_active,
  output logic [POS_W-1:0] target,
  output logic limit_hit,
  output logic frozen,
  output logic limiter_on
);

  // All checks below run on the one servo clock and are off in reset
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  // ==========================================================
  // User data registers
  // Not reset: both bound words must be written before they are selected
  // A write past the top of the file is dropped rather than aliased
  logic [POS_W-1:0] data_reg_q [NREGS];

  always_ff @(posedge clk) begin
    if (reg_wr.en && (int'(reg_wr.idx) < NREGS)) begin
      data_reg_q[reg_wr.idx] <= reg_wr.data;
    end
  end

  // ==========================================================
  // Bound selection
  logic [IDX_W-1:0] cfg_q, cfg_d;
  logic on_q, on_d;
  logic [POS_W-1:0] lower_q, lower_d;
  logic [POS_W-1:0] upper_q, upper_d;
  logic [IDX_W-1:0] hi_idx;

  // Bounds reload on every clock while on, so rewriting either word takes
  // effect two clocks later with no need to select the pair again
  always_comb begin
    cfg_d = travel_bound_config;
    hi_idx = cfg_q + CFG_NEXT;
    // Out-of-range selections act as off rather than reading stray words
    on_d = (cfg_q != CFG_OFF) && (cfg_q >= CFG_MIN) && (cfg_q <= CFG_MAX)
      && (int'(hi_idx) < NREGS);
    lower_d = lower_q;
    upper_d = upper_q;
    if (on_d) begin
      lower_d = data_reg_q[cfg_q];
      upper_d = data_reg_q[hi_idx];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cfg_q <= CFG_OFF;
      on_q <= 1'b0;
      lower_q <= BND_RST;
      upper_q <= BND_RST;
    end else begin
      cfg_q <= cfg_d;
      on_q <= on_d;
      lower_q <= lower_d;
      upper_q <= upper_d;
    end
  end

  // ==========================================================
  // Target update
  ttl_state_t state_q, state_d;
  logic [POS_W-1:0] target_q, target_d;
  logic hit_q, hit_d;
  logic frozen_q, frozen_d;
  logic signed [POS_W-1:0] cur_s, nxt_s, lo_s, hi_s;
  logic step_use;
  logic blk;
  logic hit;
  logic [POS_W-1:0] clamp;

  // Signed views: an unsigned compare would put every negative target above both bounds
  assign cur_s = target_q;
  assign nxt_s = step.pos;
  assign lo_s = lower_q;
  assign hi_s = upper_q;
  assign step_use = step.valid && (state_q == ST_TRACK);

  always_comb begin
    blk = 1'b0;
    hit = 1'b0;
    clamp = step.pos;
    if (on_q) begin
      // Direction comes from the trajectory; a step against it can only be a wrap
      if (step.neg) begin
        if (nxt_s > cur_s) begin
          blk = 1'b1;
        end else if (nxt_s <= lo_s) begin
          if (cur_s <= lo_s) begin
            // Already below, or inside a crossed-bound dead zone
            blk = 1'b1;
          end else begin
            // One count inside the bound, as the permitted range is open
            clamp = lower_q + POS_ONE;
            hit = 1'b1;
          end
        end
      end else begin
        if (nxt_s < cur_s) begin
          blk = 1'b1;
        end else if (nxt_s >= hi_s) begin
          if (cur_s >= hi_s) begin
            blk = 1'b1;
          end else begin
            clamp = upper_q - POS_ONE;
            hit = 1'b1;
          end
        end
      end
    end
  end

  always_comb begin
    state_d = state_q;
    target_d = target_q;
    hit_d = 1'b0;
    unique case (state_q)
      ST_TRACK: begin
        if (step_use && !blk) begin
          target_d = clamp;
        end
        if (step_use && hit) begin
          hit_d = 1'b1;
          state_d = ST_FROZEN;
        end
      end
      ST_FROZEN: begin
        // Trajectory output is dropped until the move ends
        if (!move_active) begin
          state_d = ST_TRACK;
        end
      end
    endcase
    // A hit in the same cycle as a direct write still freezes the move
    // Direct writes win and are never checked against the bounds
    if (tgt_wr.en) begin
      target_d = tgt_wr.data;
    end
    frozen_d = (state_d == ST_FROZEN);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= ST_TRACK;
      target_q <= TGT_RST;
      hit_q <= 1'b0;
      frozen_q <= 1'b0;
    end else begin
      state_q <= state_d;
      target_q <= target_d;
      hit_q <= hit_d;
      frozen_q <= frozen_d;
    end
  end

  assign target = target_q;
  assign limit_hit = hit_q;
  assign frozen = frozen_q;
  assign limiter_on = on_q;

  // ==========================================================
  // Checks
  // Antecedents other than direct_write_a leave out direct writes, which legally bypass every bound

  low_bound_kept_a: assert property (
    on_q && step_use && step.neg && !tgt_wr.en && (cur_s > lo_s) && !(nxt_s > cur_s)
    |=> ($signed(target_q) > $signed($past(lower_q)))
  ) else $error("target fell to or below lower bound");

  high_bound_kept_a: assert property (
    on_q && step_use && !step.neg && !tgt_wr.en && (cur_s < hi_s) && !(nxt_s < cur_s)
    |=> ($signed(target_q) < $signed($past(upper_q)))
  ) else $error("target rose to or above upper bound");

  upper_ignored_neg_a: assert property (
    on_q && step_use && step.neg && !tgt_wr.en && (nxt_s <= cur_s) && (nxt_s > lo_s)
    |=> (target_q == $past(step.pos))
  ) else $error("negative step limited by something other than lower bound");

  away_blocked_a: assert property (
    on_q && step_use && step.neg && !tgt_wr.en && (cur_s <= lo_s)
    |=> $stable(target_q)
  ) else $error("motion away from range changed target");

  hit_freezes_a: assert property (
    on_q && step_use && hit && !tgt_wr.en
    |=> limit_hit && frozen && (target_q == $past(clamp))
  ) else $error("bound hit did not stop target at bound");

  frozen_hold_a: assert property (
    frozen && move_active && !tgt_wr.en ##1 !tgt_wr.en |=> $stable(target_q)
  ) else $error("frozen move still wrote target");

  direct_write_a: assert property (
    tgt_wr.en |=> (target_q == $past(tgt_wr.data))
  ) else $error("direct target write not taken");

  wrap_blocked_a: assert property (
    on_q && step_use && !step.neg && !tgt_wr.en && (nxt_s < cur_s)
    |=> $stable(target_q) && !limit_hit
  ) else $error("wrapping positive step moved target");

  off_passes_a: assert property (
    !on_q && step_use && !tgt_wr.en |=> (target_q == $past(step.pos)) && !frozen
  ) else $error("disabled limiter altered target");

  // ==========================================================
  // Further checks

  bounds_follow_regs_a: assert property (
    on_d && !reg_wr.en
    |=> (lower_q == data_reg_q[$past(cfg_q)]) && (upper_q == data_reg_q[$past(cfg_q) + CFG_NEXT])
  ) else $error("bounds not taken from the selected register pair");

  range_selects_a: assert property (
    (travel_bound_config >= CFG_MIN) && (travel_bound_config <= CFG_MAX)
    && (int'(travel_bound_config) < NREGS - 1) |-> ##2 limiter_on
  ) else $error("valid register selection did not turn limiter on");

  off_selected_a: assert property (
    (travel_bound_config == CFG_OFF) |-> ##2 !limiter_on
  ) else $error("zero selection left limiter on");

  lower_ignored_pos_a: assert property (
    on_q && step_use && !step.neg && !tgt_wr.en && (nxt_s >= cur_s) && (nxt_s < hi_s)
    |=> (target_q == $past(step.pos))
  ) else $error("positive step limited by something other than upper bound");

  high_away_blocked_a: assert property (
    on_q && step_use && !step.neg && !tgt_wr.en && (cur_s >= hi_s)
    |=> $stable(target_q)
  ) else $error("positive motion beyond upper bound changed target");

  low_clamp_value_a: assert property (
    on_q && step_use && step.neg && !tgt_wr.en && (cur_s > lo_s) && (nxt_s <= lo_s)
    |=> (target_q == ($past(lower_q) + POS_ONE))
  ) else $error("negative hit not stopped just above lower bound");

  high_clamp_value_a: assert property (
    on_q && step_use && !step.neg && !tgt_wr.en && (cur_s < hi_s) && (nxt_s >= hi_s)
    |=> (target_q == ($past(upper_q) - POS_ONE))
  ) else $error("positive hit not stopped just below upper bound");

  hit_one_cycle_a: assert property (
    limit_hit |=> !limit_hit
  ) else $error("hit flag stood longer than one cycle");

  frozen_stays_a: assert property (
    frozen && move_active |=> frozen
  ) else $error("freeze ended while move still running");

  frozen_release_a: assert property (
    frozen && !move_active |=> !frozen
  ) else $error("freeze outlived the end of the move");

  neg_wrap_blocked_a: assert property (
    on_q && step_use && step.neg && !tgt_wr.en && (nxt_s > cur_s)
    |=> $stable(target_q) && !limit_hit
  ) else $error("wrapping negative step moved target");

  dead_zone_hold_a: assert property (
    on_q && step_use && !tgt_wr.en && (lo_s >= hi_s) && (cur_s <= lo_s) && (cur_s >= hi_s)
    |=> $stable(target_q) && !frozen
  ) else $error("servo moved inside the dead zone");

endmodule : ttl_target_travel_limiter

`default_nettype wire

/* src/ttl_pkg.sv */
// Purpose: Shared constants and types for the target travel limiter.
// Assumes: One servo clock domain; positions are two's-complement words.
// Notes: Bound words live in a small user data register file inside the block.

package ttl_pkg;

  // ==========================================================
  // Widths and sizes
  localparam int POS_W = 32;
  localparam int IDX_W = 8;
  localparam int NUM_REGS = 200;

  // ==========================================================
  // Bound configuration encodings
  localparam logic [IDX_W-1:0] CFG_OFF = 8'h00;
  localparam logic [IDX_W-1:0] CFG_MIN = 8'h0A;
  localparam logic [IDX_W-1:0] CFG_MAX = 8'hC6;
  localparam logic [IDX_W-1:0] CFG_NEXT = 8'h01;

  // ==========================================================
  // Reset values and the one-count offset
  localparam logic [POS_W-1:0] TGT_RST = 32'h0000_0000;
  localparam logic [POS_W-1:0] BND_RST = 32'h0000_0000;
  localparam logic [POS_W-1:0] POS_ONE = 32'h0000_0001;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic valid;
    logic neg;
    logic [POS_W-1:0] pos;
  } ttl_step_t;

  typedef struct packed {
    logic en;
    logic [IDX_W-1:0] idx;
    logic [POS_W-1:0] data;
  } ttl_reg_wr_t;

  typedef struct packed {
    logic en;
    logic [POS_W-1:0] data;
  } ttl_tgt_wr_t;

  typedef enum logic {
    ST_TRACK = 1'b0,
    ST_FROZEN = 1'b1
  } ttl_state_t;

endpackage : ttl_pkg

/* verification/ttl_host_model.sv */
// Purpose: Host side that writes bound registers, config, targets and steps.
// Assumes: Inputs change just after a rising edge of clk.
// Notes: Register, target and step requests are one-cycle pulses, then released; the config is held.
`timescale 1ns/1ps
`default_nettype none
module ttl_host_model
  import ttl_pkg::*;
(
  input wire logic clk,
  output var logic [IDX_W-1:0] travel_bound_config,
  output var ttl_reg_wr_t reg_wr,
  output var ttl_tgt_wr_t tgt_wr,
  output var ttl_step_t step,
  output var logic move_active
);
  initial begin
    travel_bound_config = CFG_OFF;
    reg_wr = '0;
    tgt_wr = '0;
    step = '0;
    move_active = 1'b1;
  end
  // Kind 0 writes a data register, 1 the target, 2 sends a step
  task automatic op(input int k, input logic n, input logic [POS_W-1:0] v, input logic [IDX_W-1:0] i);
    @(posedge clk);
    if (k == 0) reg_wr <= '{1'b1, i, v};
    else if (k == 1) tgt_wr <= '{1'b1, v};
    else step <= '{1'b1, n, v};
    @(posedge clk);
    reg_wr.en <= 1'b0;
    tgt_wr.en <= 1'b0;
    step.valid <= 1'b0;
  endtask : op
  // Zero here turns the limiter off
  task automatic set_cfg(input logic [IDX_W-1:0] n);
    @(posedge clk);
    travel_bound_config <= n;
    repeat (2) @(posedge clk);
  endtask : set_cfg
  task automatic pause();
    @(posedge clk);
    move_active <= 1'b0;
    @(posedge clk);
    move_active <= 1'b1;
  endtask : pause
endmodule : ttl_host_model
`default_nettype wire

/* verification/testbench.sv */
// Purpose: Directed checks of the travel limiter.
// Assumes: Bounds 100 and 200 in data registers 10 and 11; t_dead rewrites them to 300 and 100.
// Notes: Expected targets are worked out by hand.
`timescale 1ns/1ps
`default_nettype none
module testbench
  import ttl_pkg::*;
;
  logic clk, rstn, limit_hit, frozen, limiter_on;
  logic [IDX_W-1:0] cfg;
  ttl_reg_wr_t reg_wr;
  ttl_tgt_wr_t tgt_wr;
  ttl_step_t step;
  logic move_active;
  logic [POS_W-1:0] target;
  int err_total = 0;
  int compares = 0;
  int cyc = 0;
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  ttl_host_model u_host (.clk(clk), .travel_bound_config(cfg), .reg_wr(reg_wr), .tgt_wr(tgt_wr),
    .step(step), .move_active(move_active));
  ttl_target_travel_limiter u_dut (.clk(clk), .rstn(rstn), .travel_bound_config(cfg), .reg_wr(reg_wr),
    .tgt_wr(tgt_wr), .step(step), .move_active(move_active), .target(target), .limit_hit(limit_hit),
    .frozen(frozen), .limiter_on(limiter_on));
  task automatic report_and_stop();
    if (err_total == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [POS_W-1:0] got, input logic [POS_W-1:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic mv(input int k, input logic n, input logic [POS_W-1:0] v, input logic [POS_W-1:0] e);
    u_host.op(k, n, v, 8'h00);
    #1;
    chk(target, e);
  endtask : mv
  task automatic t_off();
    mv(2, 1'b0, 32'h0000_0123, 32'h0000_0123);
    chk({31'b0, limiter_on}, TGT_RST);
  endtask : t_off
  task automatic t_clamp();
    u_host.op(0, 1'b0, 32'h0000_0064, 8'h0A);
    u_host.op(0, 1'b0, 32'h0000_00C8, 8'h0B);
    u_host.set_cfg(8'h0A);
    #1;
    chk({31'b0, limiter_on}, POS_ONE);
    mv(1, 1'b0, 32'h0000_0096, 32'h0000_0096);
    mv(2, 1'b1, 32'h0000_0078, 32'h0000_0078);
    mv(2, 1'b1, 32'h0000_005A, 32'h0000_0065);
    chk({31'b0, limit_hit}, POS_ONE);
    mv(2, 1'b1, 32'h0000_005F, 32'h0000_0065);
    u_host.pause();
    #1;
    chk({31'b0, frozen}, TGT_RST);
    mv(2, 1'b0, 32'h0000_00FA, 32'h0000_00C7);
    u_host.pause();
  endtask : t_clamp
  task automatic t_out();
    mv(1, 1'b0, 32'h0000_012C, 32'h0000_012C);
    mv(2, 1'b0, 32'h0000_015E, 32'h0000_012C);
    mv(2, 1'b1, 32'h0000_0104, 32'h0000_0104);
    mv(2, 1'b1, 32'h0000_010E, 32'h0000_0104);
    mv(1, 1'b0, 32'hFFFF_FFF6, 32'hFFFF_FFF6);
    mv(2, 1'b1, 32'hFFFF_FFEC, 32'hFFFF_FFF6);
    mv(2, 1'b0, 32'h0000_0032, 32'h0000_0032);
  endtask : t_out
  task automatic t_dead();
    u_host.op(0, 1'b0, 32'h0000_012C, 8'h0A);
    u_host.op(0, 1'b0, 32'h0000_0064, 8'h0B);
    repeat (2) @(posedge clk);
    mv(1, 1'b0, 32'h0000_00C8, 32'h0000_00C8);
    mv(2, 1'b0, 32'h0000_00D2, 32'h0000_00C8);
    mv(2, 1'b1, 32'h0000_00BE, 32'h0000_00C8);
    u_host.set_cfg(CFG_OFF);
    #1;
    chk({31'b0, limiter_on}, TGT_RST);
    mv(2, 1'b0, 32'h0000_01F4, 32'h0000_01F4);
  endtask : t_dead
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      report_and_stop();
    end
  end
  initial begin
    rstn = 1'b0;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    t_off();
    t_clamp();
    t_out();
    t_dead();
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
